// [adc_seq_pkg.sv]
/*
 * Shared constants of the serial converter sequencer: register map,
 * field layout, reset values, pin indices and edge counts.
 * Assumes a 32-bit AHB-Lite register bus and a 10-bit result.
 */
package adc_seq_pkg;
   // -----------------------------------------------------------------
   // Register map (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] RESULT_OFS = 8'h04;
   localparam logic [7:0] COMMAND_OFS = 8'h08;
   localparam int ADDR_BITS = 8;

   // -----------------------------------------------------------------
   // Widths, fields and reset values
   // -----------------------------------------------------------------
   localparam int CMD_BITS = 4;
   localparam int RES_BITS = 10;
   localparam int ST_CHAN_LSB = 0;
   localparam int ST_MODE_BIT = 4;
   localparam int ST_BUSY_BIT = 5;
   localparam int ST_SAMPLING_BIT = 6;
   localparam int ST_EXT_BIT = 7;
   localparam int ST_FRAMED_BIT = 8;
   localparam logic [9:0] RESULT_RST = 10'h000;
   localparam logic [3:0] CMD_RST = 4'h0;

   // -----------------------------------------------------------------
   // Edge counts of one transfer
   // -----------------------------------------------------------------
   localparam logic [4:0] CMD_EDGES = 5'h04;
   localparam logic [4:0] CONV_EDGE = 5'h0A;
   localparam logic [4:0] EDGE_MAX = 5'h1F;

   // -----------------------------------------------------------------
   // Pin indices into the synchroniser bank
   // -----------------------------------------------------------------
   localparam int NPINS = 6;
   localparam int PIN_CS = 0;
   localparam int PIN_CLK = 1;
   localparam int PIN_DIN = 2;
   localparam int PIN_FS = 3;
   localparam int PIN_INV = 4;
   localparam int PIN_SAMPLE_START_PIN = 5;
endpackage

// [adc_seq_ifs.sv]
/*
 * Carriers between the sequencer top and its two helpers: filtered pin
 * levels with edge pulses, and the register access strobes.
 * Assumes all parties run on hclk.
 */
`timescale 1ns/10ps
`default_nettype none

// Filtered pins with one-cycle edge pulses
interface pin_if;
   logic [adc_seq_pkg::NPINS-1:0] lvl;
   logic [adc_seq_pkg::NPINS-1:0] rise;
   logic [adc_seq_pkg::NPINS-1:0] fall;
   modport sampler (output lvl, rise, fall);
   modport user (input lvl, rise, fall);
endinterface

// Register access from the bus slave
interface reg_if;
   logic [adc_seq_pkg::ADDR_BITS-1:0] rd_addr;
   logic [31:0] rd_data;
   logic wr_en;
   logic [adc_seq_pkg::ADDR_BITS-1:0] wr_addr;
   logic [31:0] wr_data;
   modport slave (output rd_addr, wr_en, wr_addr, wr_data, input rd_data);
   modport regs (input rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface

`default_nettype wire

// [pin_sampler.sv]
/*
 * Three-flop synchroniser bank for the asynchronous pins. A level is
 * accepted once the second and third stages agree; edges are pulses.
 * Assumes pins are asynchronous to hclk.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_sampler
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [adc_seq_pkg::NPINS-1:0] pins,
   pin_if.sampler po
);
   // -----------------------------------------------------------------
   // Per-pin filter
   // -----------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < adc_seq_pkg::NPINS; i++)
      begin : g_pin
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic lvl_q;
         logic rise_q;
         logic fall_q;
         // Shift chain, pins idle high
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               s1_q <= 1'b1;
               s2_q <= 1'b1;
               s3_q <= 1'b1;
            end
            else
            begin
               s1_q <= pins[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end
         // Accept agreed level, flag its edges
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               lvl_q <= 1'b1;
               rise_q <= 1'b0;
               fall_q <= 1'b0;
            end
            else
            begin
               rise_q <= (s2_q == s3_q) && s3_q && !lvl_q;
               fall_q <= (s2_q == s3_q) && !s3_q && lvl_q;
               if (s2_q == s3_q)
                  lvl_q <= s3_q;
            end
         end
         assign po.lvl[i] = lvl_q;
         assign po.rise[i] = rise_q;
         assign po.fall[i] = fall_q;
      end
   endgenerate
endmodule

`default_nettype wire

// [ahb_slave.sv]
/*
 * AHB-Lite slave for the sequencer registers. Zero wait states,
 * always OKAY; reads are registered during the address phase.
 * Assumes single word transfers from one master.
 */
`timescale 1ns/10ps
`default_nettype none

module ahb_slave
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   reg_if.slave rb
);
   logic wr_pend_q;
   logic [adc_seq_pkg::ADDR_BITS-1:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic take;

   // -----------------------------------------------------------------
   // Address phase decode
   // -----------------------------------------------------------------
   assign take = hsel && hready && htrans[1];
   assign rb.rd_addr = haddr[adc_seq_pkg::ADDR_BITS-1:0];
   assign rb.wr_en = wr_pend_q;
   assign rb.wr_addr = wr_addr_q;
   assign rb.wr_data = hwdata;

   // Remember a write for its data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= '0;
      end
      else
      begin
         // Writes outside the window are dropped, not aliased
         wr_pend_q <= take && hwrite && (hsize == 3'h2) && (haddr[31:adc_seq_pkg::ADDR_BITS] == '0);
         wr_addr_q <= haddr[adc_seq_pkg::ADDR_BITS-1:0];
      end
   end

   // Read data held until the next read
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_q <= 32'h00000000;
      else if (take && !hwrite)
         hrdata_q <= (haddr[31:adc_seq_pkg::ADDR_BITS] == '0) ? rb.rd_data : 32'h00000000;
   end

   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule

`default_nettype wire

// [adc_seq.sv]
/*
 * Serial interface sequencer of a 10-bit converter: command capture,
 * sampling window, result shift-out and conversion handoff, with a
 * register window over AHB-Lite. Software finishes a conversion by
 * writing the result. Assumes pins asynchronous to hclk; io_clk well
 * below hclk/8 so each of its edges is seen.
 */
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none

module adc_seq
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic chip_select_n,
   input wire logic io_clk,
   input wire logic data_in,
   input wire logic frame_sync,
   input wire logic clock_invert,
   input wire logic sample_start_pin,
   output logic data_out,
   output logic data_out_oe,
   output logic conversion_done,
   output logic sampling,
   output logic [3:0] channel
);
   pin_if pi ();
   reg_if rb ();

   logic mode_q;
   logic framed_q;
   logic [4:0] a_cnt_q;
   logic [4:0] b_cnt_q;
   logic [4:0] cap_cnt_q;
   logic [3:0] cmd_sh_q;
   logic [3:0] channel_q;
   logic [9:0] out_sh_q;
   logic data_out_q;
   logic data_out_oe_q;
   logic done_q;
   logic sampling_q;
   logic ext_q;
   logic [9:0] result_q;

   logic cs_low;
   logic cs_fall;
   logic cs_rise;
   logic fs_lvl;
   logic start_ev;
   logic dsp_reset;
   logic a_edge;
   logic b_edge;
   logic cap_edge;
   logic res_wr;
   logic conv_start;
   logic tenth_a;

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   pin_sampler u_pins
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .pins({sample_start_pin, clock_invert, frame_sync, data_in, io_clk, chip_select_n}),
      .po(pi)
   );

   ahb_slave u_bus
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .rb(rb)
   );

   // -----------------------------------------------------------------
   // Event decode
   // -----------------------------------------------------------------
   assign cs_low = !pi.lvl[adc_seq_pkg::PIN_CS];
   assign cs_fall = pi.fall[adc_seq_pkg::PIN_CS];
   assign cs_rise = pi.rise[adc_seq_pkg::PIN_CS];
   assign fs_lvl = pi.lvl[adc_seq_pkg::PIN_FS];
   // Micro cycle opens at select fall, DSP cycle at frame fall
   assign start_ev = (cs_fall && fs_lvl)
      || (!mode_q && cs_low && !cs_fall && pi.fall[adc_seq_pkg::PIN_FS]);
   // DSP state machine reset on falling clock while frame high
   assign dsp_reset = !mode_q && fs_lvl && pi.fall[adc_seq_pkg::PIN_CLK];
   // Edge roles swap with the mode flag; select high masks them
   assign a_edge = framed_q && cs_low && !cs_fall && !start_ev
      && (mode_q ? pi.rise[adc_seq_pkg::PIN_CLK] : pi.fall[adc_seq_pkg::PIN_CLK]);
   assign b_edge = framed_q && cs_low && !cs_fall && !start_ev
      && (mode_q ? pi.fall[adc_seq_pkg::PIN_CLK] : pi.rise[adc_seq_pkg::PIN_CLK]);
   // Command capture edge follows the invert strap
   assign cap_edge = pi.lvl[adc_seq_pkg::PIN_INV] ? a_edge : b_edge;
   assign tenth_a = a_edge && (a_cnt_q == adc_seq_pkg::CONV_EDGE - 5'h01);
   assign res_wr = rb.wr_en && (rb.wr_addr == adc_seq_pkg::RESULT_OFS);
   assign conv_start = (tenth_a && !ext_q) || pi.rise[adc_seq_pkg::PIN_SAMPLE_START_PIN];

   // -----------------------------------------------------------------
   // Mode flag and frame state
   // -----------------------------------------------------------------
   // Mode latched from frame sync at every select fall
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_q <= 1'b1;
      else if (cs_fall)
         mode_q <= fs_lvl;
   end

   // Frame open from its start until select rise, select fall or a DSP reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         framed_q <= 1'b0;
      else if (start_ev)
         framed_q <= 1'b1;
      else if (cs_fall || cs_rise || dsp_reset)
         framed_q <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Edge counters, restarted at each frame start
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_cnt_q <= 5'h00;
         b_cnt_q <= 5'h00;
      end
      else if (start_ev || cs_fall)
      begin
         a_cnt_q <= 5'h00;
         b_cnt_q <= 5'h00;
      end
      else
      begin
         if (a_edge && a_cnt_q != adc_seq_pkg::EDGE_MAX)
            a_cnt_q <= a_cnt_q + 5'h01;
         if (b_edge && b_cnt_q != adc_seq_pkg::EDGE_MAX)
            b_cnt_q <= b_cnt_q + 5'h01;
      end
   end

   // -----------------------------------------------------------------
   // Command capture, MSB first; later input bits ignored
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cap_cnt_q <= 5'h00;
         cmd_sh_q <= adc_seq_pkg::CMD_RST;
      end
      else if (start_ev || cs_fall)
         cap_cnt_q <= 5'h00;
      else if (cap_edge && cap_cnt_q < adc_seq_pkg::CMD_EDGES)
      begin
         cap_cnt_q <= cap_cnt_q + 5'h01;
         cmd_sh_q <= {cmd_sh_q[2:0], pi.lvl[adc_seq_pkg::PIN_DIN]};
      end
   end

   // Channel valid after the fourth capture edge
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         channel_q <= adc_seq_pkg::CMD_RST;
      else if (cap_edge && cap_cnt_q == adc_seq_pkg::CMD_EDGES - 5'h01)
         channel_q <= {cmd_sh_q[2:0], pi.lvl[adc_seq_pkg::PIN_DIN]};
   end

   // -----------------------------------------------------------------
   // Result shift-out: MSB at frame start, zeros after the LSB
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         out_sh_q <= adc_seq_pkg::RESULT_RST;
         data_out_q <= 1'b0;
      end
      else if (start_ev)
      begin
         out_sh_q <= result_q;
         data_out_q <= result_q[adc_seq_pkg::RES_BITS-1];
      end
      else if (b_edge)
      begin
         out_sh_q <= {out_sh_q[8:0], 1'b0};
         data_out_q <= out_sh_q[adc_seq_pkg::RES_BITS-2];
      end
   end

   // Output driven only while select is low
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         data_out_oe_q <= 1'b0;
      else
         data_out_oe_q <= cs_low;
   end

   // -----------------------------------------------------------------
   // Sampling window and extended sampling
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sampling_q <= 1'b0;
         ext_q <= 1'b0;
      end
      else if (pi.fall[adc_seq_pkg::PIN_SAMPLE_START_PIN])
      begin
         sampling_q <= 1'b1;
         ext_q <= 1'b1;
      end
      else if (pi.rise[adc_seq_pkg::PIN_SAMPLE_START_PIN])
      begin
         sampling_q <= 1'b0;
         ext_q <= 1'b0;
      end
      else if (cs_fall && !ext_q)
         sampling_q <= 1'b0;
      else if (!ext_q && b_edge && b_cnt_q == adc_seq_pkg::CMD_EDGES - 5'h01)
         sampling_q <= 1'b1;
      else if (tenth_a && !ext_q)
         sampling_q <= 1'b0;
   end

   // -----------------------------------------------------------------
   // Conversion state: done low while busy, result from software
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         done_q <= 1'b1;
      else if (conv_start)
         done_q <= 1'b0;
      else if (res_wr)
         done_q <= 1'b1;
   end

   // Result kept across aborted cycles
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         result_q <= adc_seq_pkg::RESULT_RST;
      else if (res_wr)
         result_q <= rb.wr_data[adc_seq_pkg::RES_BITS-1:0];
   end

   // -----------------------------------------------------------------
   // Register read mux
   // -----------------------------------------------------------------
   always_comb
   begin
      rb.rd_data = 32'h00000000;
      unique case (rb.rd_addr)
         adc_seq_pkg::STATUS_OFS:
         begin
            rb.rd_data[adc_seq_pkg::ST_CHAN_LSB +: adc_seq_pkg::CMD_BITS] = channel_q;
            rb.rd_data[adc_seq_pkg::ST_MODE_BIT] = mode_q;
            rb.rd_data[adc_seq_pkg::ST_BUSY_BIT] = !done_q;
            rb.rd_data[adc_seq_pkg::ST_SAMPLING_BIT] = sampling_q;
            rb.rd_data[adc_seq_pkg::ST_EXT_BIT] = ext_q;
            rb.rd_data[adc_seq_pkg::ST_FRAMED_BIT] = framed_q;
         end
         adc_seq_pkg::RESULT_OFS:
            rb.rd_data[adc_seq_pkg::RES_BITS-1:0] = result_q;
         adc_seq_pkg::COMMAND_OFS:
            rb.rd_data[adc_seq_pkg::CMD_BITS-1:0] = cmd_sh_q;
         default:
            rb.rd_data = 32'h00000000;
      endcase
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign data_out = data_out_q;
   assign data_out_oe = data_out_oe_q;
   assign conversion_done = done_q;
   assign sampling = sampling_q;
   assign channel = channel_q;
endmodule

`default_nettype wire

// [adc_seq_asserts.sv]
/*
 * Checker of the converter sequencer: pin, serial and bus relations.
 * Assumes it is bound to adc_seq and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none

module adc_seq_asserts
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic chip_select_n,
   input wire logic io_clk,
   input wire logic data_in,
   input wire logic frame_sync,
   input wire logic clock_invert,
   input wire logic sample_start_pin,
   input wire logic data_out,
   input wire logic data_out_oe,
   input wire logic conversion_done,
   input wire logic sampling,
   input wire logic [3:0] channel
);
   logic take;
   logic wr_res_q;
   logic rd_bad_q;
   logic [3:0] quiet_q;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   // ------
   // Helpers
   // ------
   // Address phase taken by the slave
   assign take = hsel && hready && htrans[1];

   // Access decode, seen during the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_res_q <= 1'b0;
         rd_bad_q <= 1'b0;
      end
      else
      begin
         wr_res_q <= take && hwrite && hsize == 3'h2 && haddr == {24'h000000, adc_seq_pkg::RESULT_OFS};
         rd_bad_q <= take && !hwrite && (haddr[31:8] != 24'h000000 || haddr[7:0] > adc_seq_pkg::COMMAND_OFS);
      end
   end

   // Cycles since the last serial pin event, saturating
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         quiet_q <= 4'hF;
      else if ($changed(io_clk) || $changed(chip_select_n) || $changed(frame_sync))
         quiet_q <= 4'h0;
      else if (quiet_q != 4'hF)
         quiet_q <= quiet_q + 4'h1;
   end

   // ------
   // Assertions and covers
   // ------
   AST_OE_OFF: assert property (chip_select_n [*8] |-> !data_out_oe)
      else $error("output driven while deselected");
   AST_OE_ON: assert property ($fell(chip_select_n) |-> ##[2:8] data_out_oe)
      else $error("output not driven after select");
   AST_DONE_SAMPLE: assert property ($fell(conversion_done) |-> ##[0:1] !sampling)
      else $error("still sampling after conversion start");
   AST_DONE_HOLD: assert property ($rose(conversion_done) |-> $past(wr_res_q) || $past(wr_res_q, 2))
      else $error("done rose without result write");
   AST_CHAN_SEL: assert property ($changed(channel) |-> !chip_select_n)
      else $error("channel changed while deselected");
   AST_DOUT_EDGE: assert property (data_out_oe && $changed(data_out) |-> quiet_q < 4'h8)
      else $error("serial output moved without a pin edge");
   AST_EXT_OPEN: assert property ($fell(sample_start_pin) |-> ##[2:8] sampling)
      else $error("start pin fall did not open sampling");
   AST_EXT_CONV: assert property ($rose(sample_start_pin) |-> ##[2:8] (!sampling && !conversion_done))
      else $error("start pin rise did not start conversion");
   AST_UNMAPPED: assert property (rd_bad_q |-> hrdata == 32'h00000000 && !hresp)
      else $error("unmapped read not zero");
   cover property ($fell(conversion_done));
   cover property ($rose(sampling) && !chip_select_n);
   cover property ($rose(data_out_oe));
   cover property (rd_bad_q);
endmodule

bind adc_seq adc_seq_asserts adc_seq_asserts_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
   .hwdata, .hready, .hrdata, .hreadyout, .hresp, .chip_select_n, .io_clk, .data_in, .frame_sync,
   .clock_invert, .sample_start_pin, .data_out, .data_out_oe, .conversion_done, .sampling, .channel);

`default_nettype wire

// [serial_host.sv]
/*
 * Host serial port model: select, frame sync, clock and command out,
 * result bits in. Assumes the sequencer on the far side.
 */
`timescale 1ns/10ps
`default_nettype none

module serial_host
(
   output logic chip_select_n,
   output logic io_clk,
   output logic data_in,
   output logic frame_sync,
   input wire logic data_out
);
   // Idle: deselected, frame sync high, clock low
   initial
   begin
      chip_select_n = 1'b1;
      io_clk = 1'b0;
      data_in = 1'b0;
      frame_sync = 1'b1;
   end

   // One transfer of nclk cycles of 125 ns; the clock rests between frames
   task automatic xfer(input logic dsp, input logic [3:0] cmd, input int nclk, output logic [15:0] got);
      int k;
      got = 16'h0000;
      #2 io_clk = dsp; // Keeps pin changes off hclk edges
      frame_sync = !dsp;
      #50 chip_select_n = 1'b0;
      #200;
      if (dsp)
      begin
         frame_sync = 1'b1;
         #200 frame_sync = 1'b0;
         #200;
      end
      for (k = 0; k < nclk; k++)
      begin
         #31 data_in = (k < 4) ? cmd[3 - k] : k[0];
         #31.5 got[15 - k] = data_out;
         io_clk = !io_clk;
         #62.5 io_clk = !io_clk;
      end
      #200 frame_sync = 1'b1;
      chip_select_n = 1'b1;
      #200;
   endtask
endmodule

`default_nettype wire

// [test_serial_adc_interface_sequencer.sv]
/*
 * Bench of the converter sequencer: register window, both host timings
 * and clock polarities, abort and extended sampling.
 * Assumes the serial_host model and the bound checker.
 */
`timescale 1ns/10ps
`default_nettype none

module test_serial_adc_interface_sequencer;
   localparam logic [31:0] ST_A = {24'h000000, adc_seq_pkg::STATUS_OFS};
   localparam logic [31:0] RES_A = {24'h000000, adc_seq_pkg::RESULT_OFS};
   localparam logic [31:0] CMD_A = {24'h000000, adc_seq_pkg::COMMAND_OFS};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic chip_select_n, io_clk, data_in, frame_sync, clock_invert, sample_start_pin;
   logic data_out, data_out_oe, conversion_done, sampling;
   logic [3:0] channel;
   logic [15:0] got;
   int err_total = 0;
   int checks_done = 0;

   adc_seq adc_seq_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .chip_select_n, .io_clk, .data_in, .frame_sync,
      .clock_invert, .sample_start_pin, .data_out, .data_out_oe, .conversion_done, .sampling, .channel);
   serial_host serial_host_inst (.chip_select_n, .io_clk, .data_in, .frame_sync, .data_out);

   // 100 MHz clock
   initial hclk = 1'b0;
   always #5 hclk = ~hclk;

   // ------
   // Shared tasks
   // ------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Single word transfer, entered just after a rising edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rdat);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
   endtask

   task automatic complete_run();
      $display("mismatches %0d, checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ------
   // Scenarios
   // ------
   // Reset values, read-only and unmapped places, refused writes
   task automatic t_regs();
      chk({sampling, data_out_oe, conversion_done, channel}, 32'h10);
      bus(1'b0, ST_A, 32'h0, rd);
      chk(rd & 32'h1FF, 32'h1 << adc_seq_pkg::ST_MODE_BIT);
      bus(1'b1, CMD_A, 32'hF, rd);
      bus(1'b0, CMD_A, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b1, RES_A, 32'h3FF, rd);
      bus(1'b0, RES_A, 32'h0, rd);
      chk(rd, 32'h3FF);
      hsize <= 3'h0;
      bus(1'b1, RES_A, 32'h0AA, rd);
      hsize <= 3'h2;
      bus(1'b1, 32'h104, 32'h155, rd);
      bus(1'b0, RES_A, 32'h0, rd);
      chk(rd, 32'h3FF);
      bus(1'b0, 32'hC, 32'h0, rd);
      chk(rd, 32'h0);
      bus(1'b0, 32'h104, 32'h0, rd);
      chk(rd, 32'h0);
   endtask

   // Full frame: the result written first comes back, command lands
   task automatic t_frame(input logic dsp, input logic inv, input logic [3:0] cmd, input int nclk,
      input logic [9:0] res);
      clock_invert <= inv;
      bus(1'b1, RES_A, {22'h0, res}, rd);
      serial_host_inst.xfer(dsp, cmd, nclk, got);
      chk(got, {res, 6'h00} & (16'hFFFF << (16 - nclk)));
      chk(channel, cmd);
      chk({conversion_done, sampling}, 32'h0);
      chk(data_out_oe, 32'h0);
      @(posedge hclk);
      bus(1'b0, ST_A, 32'h0, rd);
      chk(rd[adc_seq_pkg::ST_MODE_BIT], !dsp);
      bus(1'b1, RES_A, 32'h0, rd);
      repeat (2) @(posedge hclk);
      chk(conversion_done, 32'h1);
   endtask

   // Select lifted after three clocks: cycle dropped, result kept
   task automatic t_abort();
      bus(1'b1, RES_A, 32'h2C3, rd);
      serial_host_inst.xfer(1'b0, 4'h9, 3, got);
      chk(got, {10'h2C3, 6'h00} & 16'hE000);
      chk({conversion_done, channel}, 32'h13);
      @(posedge hclk);
      serial_host_inst.xfer(1'b0, 4'h6, 10, got);
      chk(got, {10'h2C3, 6'h00});
      chk(channel, 4'h6);
      @(posedge hclk);
      bus(1'b1, RES_A, 32'h0, rd);
   endtask

   // Start pin owns the window, also across a full frame
   task automatic t_ext();
      sample_start_pin <= 1'b0;
      repeat (10) @(posedge hclk);
      chk({sampling, conversion_done}, 32'h3);
      serial_host_inst.xfer(1'b0, 4'h5, 10, got);
      chk({sampling, conversion_done}, 32'h3);
      @(posedge hclk);
      sample_start_pin <= 1'b1;
      repeat (10) @(posedge hclk);
      chk({sampling, conversion_done}, 32'h0);
      bus(1'b1, RES_A, 32'h155, rd);
      repeat (2) @(posedge hclk);
      chk(conversion_done, 32'h1);
   endtask

   // Main sequence
   initial
   begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      clock_invert = 1'b1;
      sample_start_pin = 1'b1;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      t_regs();
      t_frame(1'b0, 1'b1, 4'hA, 10, 10'h2B5);
      t_frame(1'b0, 1'b0, 4'h5, 16, 10'h14A);
      t_frame(1'b1, 1'b1, 4'hC, 16, 10'h3C1);
      t_frame(1'b1, 1'b0, 4'h3, 10, 10'h0F0);
      t_abort();
      t_ext();
      complete_run();
   end

   // Watchdog, well beyond the expected run
   initial
   begin
      #200000;
      err_total++;
      complete_run();
   end
endmodule

`default_nettype wire
